// ==== rtl/fsbp_pkg.sv ====
package fsbp_pkg;

	// Clock period of the serial-interface domain
	localparam int CLK_PERIOD_NS = 50;

	// Internal status-write time; a least time, so it rounds up to whole cycles
	localparam int SR_WRITE_NS = 2000;
	localparam int SR_WRITE_CYC = (SR_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Status byte field positions
	localparam int SR_WIP_BIT = 0;
	localparam int SR_WEL_BIT = 1;
	localparam int SR_RANGE_B0_BIT = 2;
	localparam int SR_RANGE_B1_BIT = 3;
	localparam int SR_RANGE_B2_BIT = 4;
	localparam int SR_BOTTOM_BIT = 5;
	localparam int SR_RANGE_B3_BIT = 6;
	localparam int SR_WRDIS_BIT = 7;

	// Flag status byte field positions
	localparam int FSR_READY_BIT = 7;
	localparam int FSR_ERASE_ERR_BIT = 5;
	localparam int FSR_PROG_ERR_BIT = 4;
	localparam int FSR_PROT_ERR_BIT = 1;

	// Array geometry
	localparam int ADDR_W = 25;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 25'h1ffffff;
	localparam int SECTOR_LSB = 16;
	localparam int SECTOR_W = 9;
	localparam int SECTOR_COUNT = 512;
	localparam logic [3:0] RANGE_NONE = 4'h0;
	localparam logic [3:0] RANGE_ALL_MIN = 4'ha;

	// Values after reset
	localparam logic NV_WRDIS_RST = 1'b0;
	localparam logic NV_BOTTOM_RST = 1'b0;
	localparam logic [3:0] NV_RANGE_RST = 4'h0;
	localparam logic WEL_RST = 1'b0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h80;

	typedef enum logic [3:0] {
		FSBP_CMD_NONE,
		FSBP_CMD_READ_STATUS,
		FSBP_CMD_WRITE_STATUS,
		FSBP_CMD_WRITE_ENABLE,
		FSBP_CMD_WRITE_DISABLE,
		FSBP_CMD_READ_FLAG,
		FSBP_CMD_CLEAR_FLAG,
		FSBP_CMD_PROGRAM,
		FSBP_CMD_ERASE_4K,
		FSBP_CMD_ERASE_32K,
		FSBP_CMD_ERASE_64K,
		FSBP_CMD_ERASE_BULK
	} fsbp_cmd_code_t;

	// One decoded command from the serial front end
	typedef struct packed {
		logic valid;
		fsbp_cmd_code_t code;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} fsbp_cmd_t;

	// Nonvolatile protection bits
	typedef struct packed {
		logic wr_dis;
		logic bottom;
		logic [3:0] range;
	} fsbp_nv_t;

	// Array operation handed to the program/erase engine
	typedef struct packed {
		logic start;
		fsbp_cmd_code_t code;
		logic [ADDR_W-1:0] addr;
	} fsbp_op_t;

endpackage : fsbp_pkg

// ==== rtl/fsbp_range_check.sv ====
`timescale 1ns/1ns
`default_nettype none

module fsbp_range_check (
	// Protection settings
	input wire fsbp_pkg::fsbp_nv_t nv,
	// Sector under test
	input wire logic [fsbp_pkg::SECTOR_W-1:0] sector,
	// Result
	output logic hit,
	output logic any_set
);

	logic [fsbp_pkg::SECTOR_W:0] run_len;
	logic [fsbp_pkg::SECTOR_W:0] first_top;

	// Run of 1..256 sectors; codes from 1010 on cover the whole array
	always_comb begin
		run_len = (fsbp_pkg::SECTOR_W+1)'(1) << (nv.range - 4'h1);
		first_top = (fsbp_pkg::SECTOR_W+1)'(fsbp_pkg::SECTOR_COUNT) - run_len;
		any_set = (nv.range != fsbp_pkg::RANGE_NONE); // R7
		if (!any_set) begin
			hit = 1'b0; // R7
		end else if (nv.range >= fsbp_pkg::RANGE_ALL_MIN) begin
			hit = 1'b1; // R8 R9
		end else if (nv.bottom) begin
			hit = ({1'b0, sector} < run_len); // R9
		end else begin
			hit = ({1'b0, sector} >= first_top); // R8
		end
	end

endmodule : fsbp_range_check

`default_nettype wire

// ==== rtl/fsbp_status_protect.sv ====
`timescale 1ns/1ns
`default_nettype none

// What this block does
// R1: Read-status returns the status byte; write-status updates its writable bits.
// R2: Bit 7 set with write-protect pin low freezes nonvolatile bits; status writes dropped.
// R3: Only a high write-protect pin releases the frozen state; no command does.
// R4: Bit 7 is nonvolatile, default 0 meaning status writes allowed.
// R5: Bit 5 nonvolatile, default 0: protected run at top; 1 at bottom.
// R6: Range code sits in bits 6,4,3,2, bit 6 most significant.
// R7: Nonzero range code refuses program and erase into the protected area.
// R8: Top anchor: codes 1..9 protect 1..256 sectors ending at 511; above, all.
// R9: Bottom anchor: codes 1..9 protect 1..256 sectors from 0; above, all.
// R10: Bulk erase runs only with a range code of zero.
// R11: Volatile write-enable latch, clear at power-up, needed before any write.
// R12: Bit 0 is busy during status write, program or erase; default 0.
// R13: Bit 0 always equals the inverse of flag-status ready bit 7.
// R14: Array is 0 to 01FFFFFFh: 512 x 64KB, 1024 x 32KB, 8192 x 4KB.
// R15: Refused program or erase sets the protection error flag, bit 1.
// R16: Refused operations leave the array alone; protection bits survive power cycles.
module fsbp_status_protect #(
	parameter int SR_WRITE_CYCLES = fsbp_pkg::SR_WRITE_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Write-protect pin, asynchronous
	input wire logic wp_pin,
	// Decoded commands
	input wire fsbp_pkg::fsbp_cmd_t cmd,
	// Nonvolatile cell image, restored after reset
	input wire fsbp_pkg::fsbp_nv_t nv_restore,
	// Array engine completion
	input wire logic array_done,
	// Read answers
	output logic [7:0] rd_data,
	output logic rd_valid,
	// Array operation request
	output fsbp_pkg::fsbp_op_t op,
	// Nonvolatile store request
	output logic nv_store,
	output fsbp_pkg::fsbp_nv_t nv_store_data,
	// Live status
	output logic [7:0] status_byte,
	output logic [7:0] flag_byte
);

	// The wait counter is 16 bits and must run at least once
	if (SR_WRITE_CYCLES < 1 || SR_WRITE_CYCLES > 65535) begin : g_bad_write_cycles
		$error("SR_WRITE_CYCLES out of range");
	end

	typedef enum logic [1:0] {
		FSBP_ST_LOAD,
		FSBP_ST_IDLE,
		FSBP_ST_SR_WRITE,
		FSBP_ST_ARRAY
	} fsbp_state_t;

	// Write-protect pin synchroniser
	// Resets to low, so a frozen register stays frozen until the pin is seen high
	logic wp_meta_r;
	logic wp_sync_r;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wp_meta_r <= 1'b0;
			wp_sync_r <= 1'b0;
		end else begin
			wp_meta_r <= wp_pin;
			wp_sync_r <= wp_meta_r;
		end
	end

	// Control state
	fsbp_state_t state_r, state_nxt;
	fsbp_pkg::fsbp_nv_t nv_r, nv_nxt;
	logic wel_r, wel_nxt;
	logic prot_err_r, prot_err_nxt;
	logic [15:0] wait_cnt_r, wait_cnt_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	fsbp_pkg::fsbp_op_t op_r, op_nxt;
	logic nv_store_r, nv_store_nxt;
	logic [7:0] status_r, status_nxt;
	logic [7:0] flag_r, flag_nxt;

	logic hw_locked;
	logic busy;
	logic range_hit;
	logic range_any;
	logic is_array_cmd;
	logic refuse;
	logic [7:0] cur_status;
	logic [7:0] cur_flag;

	// Sector number from the top address bits
	// Purely combinational, so the decision is ready in the taking cycle
	fsbp_range_check u_range (
		.nv(nv_r),
		.sector(cmd.addr[fsbp_pkg::SECTOR_LSB +: fsbp_pkg::SECTOR_W]), // R14
		.hit(range_hit),
		.any_set(range_any)
	);

	// Pack the status byte from the live bits
	function automatic logic [7:0] pack_status(input fsbp_pkg::fsbp_nv_t nv, input logic wel, input logic wip);
		logic [7:0] b;
		b = fsbp_pkg::BYTE_RST;
		b[fsbp_pkg::SR_WRDIS_BIT] = nv.wr_dis; // R4
		b[fsbp_pkg::SR_RANGE_B3_BIT] = nv.range[3]; // R6
		b[fsbp_pkg::SR_BOTTOM_BIT] = nv.bottom; // R5
		b[fsbp_pkg::SR_RANGE_B2_BIT] = nv.range[2];
		b[fsbp_pkg::SR_RANGE_B1_BIT] = nv.range[1];
		b[fsbp_pkg::SR_RANGE_B0_BIT] = nv.range[0];
		b[fsbp_pkg::SR_WEL_BIT] = wel;
		b[fsbp_pkg::SR_WIP_BIT] = wip;
		return b;
	endfunction : pack_status

	// Pack the flag byte; error bits follow the type of the last array command
	function automatic logic [7:0] pack_flag(input logic wip, input logic prot_err, input fsbp_pkg::fsbp_cmd_code_t code);
		logic [7:0] f;
		f = fsbp_pkg::BYTE_RST;
		f[fsbp_pkg::FSR_READY_BIT] = !wip; // R13
		f[fsbp_pkg::FSR_PROT_ERR_BIT] = prot_err; // R15
		f[fsbp_pkg::FSR_PROG_ERR_BIT] = prot_err && code == fsbp_pkg::FSBP_CMD_PROGRAM;
		f[fsbp_pkg::FSR_ERASE_ERR_BIT] = prot_err && code != fsbp_pkg::FSBP_CMD_PROGRAM;
		return f;
	endfunction : pack_flag

	// Both bytes derive from one busy term so they cannot disagree
	always_comb begin
		busy = (state_r == FSBP_ST_SR_WRITE) || (state_r == FSBP_ST_ARRAY);
		hw_locked = nv_r.wr_dis && !wp_sync_r; // R2 R3
		cur_status = pack_status(nv_r, wel_r, busy); // R12
		cur_flag = pack_flag(busy, prot_err_r, op_r.code); // R13 R15
		// Array commands share the enable and protection checks
		is_array_cmd = (cmd.code == fsbp_pkg::FSBP_CMD_PROGRAM) || (cmd.code == fsbp_pkg::FSBP_CMD_ERASE_4K)
			|| (cmd.code == fsbp_pkg::FSBP_CMD_ERASE_32K) || (cmd.code == fsbp_pkg::FSBP_CMD_ERASE_64K)
			|| (cmd.code == fsbp_pkg::FSBP_CMD_ERASE_BULK);
		// Bulk erase looks at the code alone, not at the addressed sector
		if (cmd.code == fsbp_pkg::FSBP_CMD_ERASE_BULK) begin
			refuse = range_any; // R10
		end else begin
			refuse = range_hit || (cmd.addr > fsbp_pkg::ADDR_LAST); // R7 R14
		end
	end

	// Command handling and sequencing
	always_comb begin
		state_nxt = state_r;
		nv_nxt = nv_r;
		wel_nxt = wel_r;
		prot_err_nxt = prot_err_r;
		wait_cnt_nxt = wait_cnt_r;
		op_nxt = op_r;
		op_nxt.start = 1'b0;
		nv_store_nxt = 1'b0;
		unique case (state_r)
			FSBP_ST_LOAD: begin
				// Cells are caught once after release, never under reset
				nv_nxt = nv_restore; // R16
				state_nxt = FSBP_ST_IDLE;
			end
			FSBP_ST_SR_WRITE: begin
				// Counts down the internal write time
				if (wait_cnt_r == 16'h0001) begin
					state_nxt = FSBP_ST_IDLE;
				end
				wait_cnt_nxt = wait_cnt_r - 16'h0001;
			end
			FSBP_ST_ARRAY: begin
				// The engine owns the array until it reports done
				if (array_done) begin
					state_nxt = FSBP_ST_IDLE; // R12
				end
			end
			FSBP_ST_IDLE: begin
				if (cmd.valid) begin
					// One command a cycle, so a flag clear never meets a set
					unique case (cmd.code)
						fsbp_pkg::FSBP_CMD_WRITE_ENABLE: wel_nxt = 1'b1; // R11
						fsbp_pkg::FSBP_CMD_WRITE_DISABLE: wel_nxt = 1'b0;
						fsbp_pkg::FSBP_CMD_CLEAR_FLAG: prot_err_nxt = 1'b0;
						fsbp_pkg::FSBP_CMD_WRITE_STATUS: begin
							// Latch is spent even when the write is dropped
							wel_nxt = 1'b0;
							if (wel_r && !hw_locked) begin // R2 R11
								nv_nxt.wr_dis = cmd.data[fsbp_pkg::SR_WRDIS_BIT]; // R1 R4
								nv_nxt.bottom = cmd.data[fsbp_pkg::SR_BOTTOM_BIT]; // R5
								nv_nxt.range = {cmd.data[fsbp_pkg::SR_RANGE_B3_BIT],
									cmd.data[fsbp_pkg::SR_RANGE_B2_BIT],
									cmd.data[fsbp_pkg::SR_RANGE_B1_BIT],
									cmd.data[fsbp_pkg::SR_RANGE_B0_BIT]}; // R6
								// Cells take the new bits while busy stands
								nv_store_nxt = 1'b1; // R16
								wait_cnt_nxt = 16'(SR_WRITE_CYCLES);
								state_nxt = FSBP_ST_SR_WRITE; // R12
							end
						end
						default: begin
							if (is_array_cmd) begin
								wel_nxt = 1'b0;
								op_nxt.code = cmd.code;
								op_nxt.addr = cmd.addr;
								if (wel_r && refuse) begin
									prot_err_nxt = 1'b1; // R15 R16
								end else if (wel_r) begin
									op_nxt.start = 1'b1; // R7
									state_nxt = FSBP_ST_ARRAY;
								end
							end
						end
					endcase
				end
			end
		endcase
	end

	// Read answers; served in every state but load so a host can poll busy
	always_comb begin
		rd_data_nxt = rd_data_r;
		rd_valid_nxt = 1'b0;
		if (cmd.valid && state_r != FSBP_ST_LOAD) begin
			if (cmd.code == fsbp_pkg::FSBP_CMD_READ_STATUS) begin
				rd_data_nxt = cur_status; // R1
				rd_valid_nxt = 1'b1;
			end else if (cmd.code == fsbp_pkg::FSBP_CMD_READ_FLAG) begin
				rd_data_nxt = cur_flag; // R13
				rd_valid_nxt = 1'b1;
			end
		end
	end

	// Live bytes follow the next state, so they turn on the same edge as busy
	always_comb begin
		status_nxt = pack_status(nv_nxt, wel_nxt,
			(state_nxt == FSBP_ST_SR_WRITE) || (state_nxt == FSBP_ST_ARRAY)); // R12
		flag_nxt = pack_flag(status_nxt[fsbp_pkg::SR_WIP_BIT], prot_err_nxt, op_nxt.code); // R13 R15
	end

	// Control registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= FSBP_ST_LOAD;
			nv_r <= '{wr_dis: fsbp_pkg::NV_WRDIS_RST, bottom: fsbp_pkg::NV_BOTTOM_RST,
				range: fsbp_pkg::NV_RANGE_RST};
			wel_r <= fsbp_pkg::WEL_RST; // R11
			prot_err_r <= 1'b0;
			wait_cnt_r <= 16'h0000;
			op_r <= '{start: 1'b0, code: fsbp_pkg::FSBP_CMD_NONE, addr: '0};
			nv_store_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			nv_r <= nv_nxt;
			wel_r <= wel_nxt;
			prot_err_r <= prot_err_nxt;
			wait_cnt_r <= wait_cnt_nxt;
			op_r <= op_nxt;
			nv_store_r <= nv_store_nxt;
		end
	end

	// Read answer registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_r <= fsbp_pkg::BYTE_RST;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	// Live byte registers; the flag byte reads ready while held in reset
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			status_r <= fsbp_pkg::BYTE_RST;
			flag_r <= fsbp_pkg::FLAG_RST;
		end else begin
			status_r <= status_nxt;
			flag_r <= flag_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;
	assign op = op_r;
	assign nv_store = nv_store_r;
	assign nv_store_data = nv_r;
	assign status_byte = status_r;
	assign flag_byte = flag_r;

endmodule : fsbp_status_protect

`default_nettype wire

// ==== verification/fsbp_status_protect_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsbp_status_protect_chk #(
	parameter int SR_WRITE_CYCLES = 2
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Inputs
	input wire logic wp_pin,
	input wire fsbp_pkg::fsbp_cmd_t cmd,
	input wire fsbp_pkg::fsbp_nv_t nv_restore,
	input wire logic array_done,
	// Outputs
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire fsbp_pkg::fsbp_op_t op,
	input wire logic nv_store,
	input wire fsbp_pkg::fsbp_nv_t nv_store_data,
	input wire logic [7:0] status_byte,
	input wire logic [7:0] flag_byte
);
	// Slack of one sync and one edge beyond the write time
	localparam int WMAX = SR_WRITE_CYCLES + 3;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// Two views of one busy state
	a_busy_ready: assert property (status_byte[0] == !flag_byte[7])
		else $error("busy and ready disagree");
	// First edge after release is the load cycle, reads ignored there
	a_read_answer: assert property (cmd.valid && cmd.code == fsbp_pkg::FSBP_CMD_READ_STATUS && $past(rstn) |=> rd_valid)
		else $error("read status not answered");
	a_field_map: assert property (nv_store_data == {status_byte[7], status_byte[5], status_byte[6], status_byte[4:2]})
		else $error("status fields misplaced");
	// Sync takes up to three edges, so five low samples are safe
	a_lock_holds: assert property (!wp_pin [*5] ##0 $past(status_byte[7]) |-> !nv_store)
		else $error("status written while locked");
	a_store_busy: assert property (nv_store |-> status_byte[0] && !status_byte[1] ##[1:WMAX] !status_byte[0])
		else $error("status write busy wrong");
	a_start_enabled: assert property (op.start |-> $past(status_byte[1]) && status_byte[0] && !status_byte[1])
		else $error("array start without enable");
	a_bulk_clear: assert property (op.start && op.code == fsbp_pkg::FSBP_CMD_ERASE_BULK |-> nv_store_data.range == 4'h0)
		else $error("bulk erase with range set");
	a_refused_flag: assert property ($rose(flag_byte[1]) |-> !op.start && !status_byte[0])
		else $error("refused op still started");
	a_all_guard: assert property (op.start |-> nv_store_data.range < 4'ha)
		else $error("start with whole array protected");
	a_edge_guard: assert property (op.start && nv_store_data.range == 4'h1 |->
		op.addr[24:16] != (nv_store_data.bottom ? 9'h000 : 9'h1ff))
		else $error("start on single protected sector");
	// Main scenarios
	c_store: cover property (nv_store);
	c_bulk: cover property (op.start && op.code == fsbp_pkg::FSBP_CMD_ERASE_BULK);
	c_refuse: cover property ($rose(flag_byte[1]));
endmodule : fsbp_status_protect_chk
bind fsbp_status_protect fsbp_status_protect_chk #(.SR_WRITE_CYCLES(SR_WRITE_CYCLES)) u_chk (.core_clk, .rstn,
	.wp_pin, .cmd, .nv_restore, .array_done, .rd_data, .rd_valid, .op, .nv_store, .nv_store_data,
	.status_byte, .flag_byte);
`default_nettype wire

// ==== verification/fsbp_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module fsbp_far_model #(
	parameter fsbp_pkg::fsbp_nv_t NV_INIT = 6'b010011,
	parameter int DONE_CYC = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Requests from the block
	input wire fsbp_pkg::fsbp_op_t op,
	input wire logic nv_store,
	input wire fsbp_pkg::fsbp_nv_t nv_store_data,
	// Answers
	output logic array_done,
	output fsbp_pkg::fsbp_nv_t nv_restore
);
	int cnt_r;
	// Cells ignore reset, like real storage
	initial nv_restore = NV_INIT;
	always @(posedge core_clk) if (nv_store) nv_restore <= nv_store_data;
	// Engine finishes a fixed time after each start
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) cnt_r <= 0;
		else if (op.start) cnt_r <= DONE_CYC;
		else if (cnt_r != 0) cnt_r <= cnt_r - 1;
	end
	assign array_done = cnt_r == 1;
endmodule : fsbp_far_model
`default_nettype wire

// ==== verification/flash_status_block_protect_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module flash_status_block_protect_tb;
	logic core_clk, rstn, wp_pin, array_done, rd_valid, nv_store, started;
	fsbp_pkg::fsbp_cmd_t cmd;
	fsbp_pkg::fsbp_nv_t nv_restore, nv_store_data;
	fsbp_pkg::fsbp_op_t op;
	logic [7:0] rd_data, status_byte, flag_byte, rdd;
	int err_count, checks;

	// Short status-write time keeps runs brief
	fsbp_status_protect #(.SR_WRITE_CYCLES(2)) dut (.core_clk, .rstn, .wp_pin, .cmd, .nv_restore, .array_done,
		.rd_data, .rd_valid, .op, .nv_store, .nv_store_data, .status_byte, .flag_byte);
	fsbp_far_model far (.core_clk, .rstn, .op, .nv_store, .nv_store_data, .array_done, .nv_restore);

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	// One-cycle command; answers are settled at the next falling edge
	task automatic send(fsbp_pkg::fsbp_cmd_code_t c, logic [8:0] s = 9'h0, logic [7:0] d = 8'h00);
		@(negedge core_clk);
		cmd = '{1'b1, c, {s, 16'h8abc}, d};
		@(negedge core_clk);
		started = op.start;
		rdd = rd_valid ? rd_data : 8'hxx;
		cmd.valid = 1'b0;
	endtask : send
	task automatic we();
		send(fsbp_pkg::FSBP_CMD_WRITE_ENABLE);
	endtask : we
	// Bounded wait for the busy flag to drop
	task automatic idle();
		for (int i = 0; i < 60 && status_byte[0] !== 1'b0; i++) @(negedge core_clk);
		cmp("busy", 8'h00, {7'h0, status_byte[0]});
	endtask : idle
	task automatic wrs(logic [7:0] b);
		we();
		send(fsbp_pkg::FSBP_CMD_WRITE_STATUS, 9'h0, b);
		idle();
	endtask : wrs
	task automatic rds(logic [7:0] exp);
		send(fsbp_pkg::FSBP_CMD_READ_STATUS);
		cmp("status", exp, rdd);
	endtask : rds

	task automatic t_basic();
		rds(8'h2c);
		send(fsbp_pkg::FSBP_CMD_WRITE_STATUS, 9'h0, 8'h00);
		rds(8'h2c);
		we();
		rds(8'h2e);
		send(fsbp_pkg::FSBP_CMD_WRITE_DISABLE);
		rds(8'h2c);
		wrs(8'h47);
		rds(8'h44);
		send(fsbp_pkg::FSBP_CMD_READ_FLAG);
		cmp("flag read", 8'h80, rdd);
		$display("basic done");
	endtask : t_basic
	// Both anchors, every code, sectors on each side of the boundary
	task automatic t_prot();
		int n;
		logic [8:0] s;
		logic p;
		fsbp_pkg::fsbp_cmd_code_t c;
		for (int b = 0; b < 2; b++) for (int k = 0; k < 16; k++) begin
			n = k == 0 ? 0 : k > 9 ? 512 : 1 << (k - 1);
			wrs({1'b0, k[3], b[0], k[2:0], 2'b11});
			for (int j = 0; j < 2; j++) begin
				s = b ? n - 1 + j : 512 - n - j;
				p = k != 0 && (b ? s < n : s >= 512 - n);
				// Erase sizes rotate with the code so every size meets the guard
				c = !j ? fsbp_pkg::FSBP_CMD_PROGRAM : k[0] ? fsbp_pkg::FSBP_CMD_ERASE_32K
					: k[1] ? fsbp_pkg::FSBP_CMD_ERASE_4K : fsbp_pkg::FSBP_CMD_ERASE_64K;
				we();
				send(c, s);
				cmp("start", {7'h0, !p}, {7'h0, started});
				idle();
				cmp("flag", p ? (j ? 8'ha2 : 8'h92) : 8'h80, flag_byte);
				send(fsbp_pkg::FSBP_CMD_CLEAR_FLAG);
			end
		end
		$display("protect done");
	endtask : t_prot
	task automatic t_bulk();
		wrs(8'h04);
		we();
		send(fsbp_pkg::FSBP_CMD_ERASE_BULK);
		cmp("bulk start", 8'h00, {7'h0, started});
		cmp("bulk flag", 8'ha2, flag_byte);
		send(fsbp_pkg::FSBP_CMD_CLEAR_FLAG);
		wrs(8'h00);
		we();
		send(fsbp_pkg::FSBP_CMD_ERASE_BULK);
		cmp("bulk start", 8'h01, {7'h0, started});
		idle();
		$display("bulk done");
	endtask : t_bulk
	// Pin must pass the synchroniser before it counts
	task automatic t_lock();
		wrs(8'h80);
		rds(8'h80);
		wp_pin = 1'b0;
		repeat (4) @(negedge core_clk);
		wrs(8'h00);
		rds(8'h80);
		wp_pin = 1'b1;
		repeat (4) @(negedge core_clk);
		wrs(8'h00);
		rds(8'h00);
		$display("lock done");
	endtask : t_lock
	task automatic t_restore();
		wrs(8'h64);
		@(negedge core_clk) rstn = 1'b0;
		@(negedge core_clk) rstn = 1'b1;
		rds(8'h64);
		$display("restore done");
	endtask : t_restore

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	initial begin
		rstn = 1'b0;
		wp_pin = 1'b1;
		cmd = '0;
		err_count = 0;
		checks = 0;
		repeat (20) @(negedge core_clk);
		cmp("flag", 8'h80, flag_byte);
		cmp("status", 8'h00, status_byte);
		rstn = 1'b1;
		t_basic();
		t_prot();
		t_bulk();
		t_lock();
		t_restore();
		test_done();
	end
	// Tests need about a thousand cycles; this allows twenty thousand
	initial begin
		#1000000;
		err_count++;
		test_done();
	end
endmodule : flash_status_block_protect_tb
`default_nettype wire
